// *** logic/stap_top.v ***
`timescale 1ns/10ps
`include "stap_map.vh"
// ----------------------------------------
// ----------------------------------------
module stap_top #(
	parameter BSR_LEN = `STAP_BSR_LEN,
	parameter ID_LEN  = `STAP_ID_LEN,
	// Arbitrary identification value
	parameter [ID_LEN-1:0] ID_CODE = `STAP_ID_VALUE
) (
	// Clock and reset
	input  wire               REF_CLK,
	input  wire               NRST,
	// Test port pins
	input  wire               TCK,
	input  wire               TMS,
	input  wire               TDI,
	input  wire               TRST_N,
	output reg                TDO,
	output reg                TDO_OE,
	// I/O ring
	input  wire [BSR_LEN-1:0] RING_IN,
	// Data pin control
	output reg                DQ_FLOAT
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [3:0] pins_s;
	stap_sync #(
		.W (4)
	) u_sync (
		.clk  (REF_CLK),
		.nrst (NRST),
		.din  ({TCK, TMS, TDI, TRST_N}),
		.dout (pins_s)
	);
	wire tck_s  = pins_s[3];
	wire tms_s  = pins_s[2];
	wire tdi_s  = pins_s[1];
	wire trst_n_s = pins_s[0];
	reg  tck_q;
	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			tck_q <= 1'b0;
		end else begin
			tck_q <= tck_s;
		end
	end
	// Ring comes from the RAM clock domain and is synchronised like any pin
	wire [BSR_LEN-1:0] ring_s;
	stap_sync #(
		.W (BSR_LEN)
	) u_ring_sync (
		.clk  (REF_CLK),
		.nrst (NRST),
		.din  (RING_IN),
		.dout (ring_s)
	);
	wire tck_rise = tck_s & ~tck_q;
	wire tck_fall = ~tck_s & tck_q;
	// ----------------------------------------
	// Controller
	// ----------------------------------------
	wire [3:0] state_q;
	stap_fsm u_fsm (
		.clk      (REF_CLK),
		.nrst     (NRST),
		.trst_n   (trst_n_s),
		.tck_rise (tck_rise),
		.tms      (tms_s),
		.state_q  (state_q)
	);
	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	function [1:0] sel_of;
		input [2:0] op;
		begin
			case (op)
				`STAP_OP_IDCODE: sel_of = 2'h1;
				`STAP_OP_SAMPLE: sel_of = 2'h2;
				default:         sel_of = 2'h0; // Reserved codes act as bypass
			endcase
		end
	endfunction
	reg  [`STAP_IR_LEN-1:0] ir_sh_q;
	reg  [`STAP_IR_LEN-1:0] ir_q;
	reg  [ID_LEN-1:0]       id_sh_q;
	reg  [BSR_LEN-1:0]      bsr_q;
	reg                     byp_q;
	wire [1:0]              dr_sel = sel_of(ir_q);
	wire                    ring_cap = (ir_q == `STAP_OP_SAMPLE) || (ir_q == `STAP_OP_HIGHZ);
	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	// Shift is MSB-in from TDI, LSB out first, so codes read MSB on the left
	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ir_sh_q <= `STAP_OP_IDCODE;
			ir_q    <= `STAP_OP_IDCODE;
		end else if (!trst_n_s || (state_q == `STAP_ST_RESET)) begin
			// Reset state forces the default at once, not one TCK later
			ir_q    <= `STAP_OP_IDCODE;
		end else if (tck_rise) begin
			case (state_q)
				`STAP_ST_RESET:  ir_q    <= `STAP_OP_IDCODE;
				`STAP_ST_CAP_IR: ir_sh_q <= `STAP_IR_CAPTURE;
				`STAP_ST_SH_IR:  ir_sh_q <= {tdi_s, ir_sh_q[`STAP_IR_LEN-1:1]};
				`STAP_ST_UPD_IR: ir_q    <= ir_sh_q;
				default:         ir_q    <= ir_q;
			endcase
		end
	end
	// ----------------------------------------
	// Data registers
	// ----------------------------------------
	// Ring is sampled without care for the RAM clock; unstable pins give unstable bits
	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			id_sh_q <= {ID_LEN{1'b0}};
			bsr_q   <= {BSR_LEN{1'b0}};
			byp_q   <= 1'b0;
		end else if (tck_rise) begin
			if (state_q == `STAP_ST_CAP_DR) begin
				byp_q <= 1'b0;
				if (ir_q == `STAP_OP_IDCODE)
					id_sh_q <= ID_CODE;
				if (ring_cap)
					bsr_q <= ring_s;
			end else if (state_q == `STAP_ST_SH_DR) begin
				case (dr_sel)
					2'h1:    id_sh_q <= {tdi_s, id_sh_q[ID_LEN-1:1]};
					2'h2:    bsr_q   <= {tdi_s, bsr_q[BSR_LEN-1:1]};
					default: byp_q   <= tdi_s;
				endcase
			end
			// Update-DR has no effect on pins: no preload path exists
		end
	end
	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	reg tdo_d;
	always @* begin
		tdo_d = 1'b0;
		if (state_q == `STAP_ST_SH_IR)
			tdo_d = ir_sh_q[0];
		else if (state_q == `STAP_ST_SH_DR) begin
			case (dr_sel)
				2'h1:    tdo_d = id_sh_q[0];
				2'h2:    tdo_d = bsr_q[0];
				default: tdo_d = byp_q;
			endcase
		end
	end
	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			TDO      <= 1'b0;
			TDO_OE   <= 1'b0;
			DQ_FLOAT <= 1'b0;
		end else begin
			DQ_FLOAT <= (ir_q == `STAP_OP_HIGHZ);
			if (tck_fall) begin
				TDO    <= tdo_d;
				TDO_OE <= (state_q == `STAP_ST_SH_IR) || (state_q == `STAP_ST_SH_DR);
			end
		end
	end
endmodule // stap_top

// *** logic/stap_map.vh ***
`ifndef STAP_MAP_VH
`define STAP_MAP_VH
// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define STAP_IR_LEN        3
`define STAP_OP_RSV0       3'h0
`define STAP_OP_IDCODE     3'h1
`define STAP_OP_HIGHZ      3'h2
`define STAP_OP_BYPASS     3'h3
`define STAP_OP_SAMPLE     3'h4
`define STAP_IR_CAPTURE    3'h1
// ----------------------------------------
// Controller states
// ----------------------------------------
`define STAP_ST_RESET      4'h0
`define STAP_ST_IDLE       4'h1
`define STAP_ST_SEL_DR     4'h2
`define STAP_ST_CAP_DR     4'h3
`define STAP_ST_SH_DR      4'h4
`define STAP_ST_EX1_DR     4'h5
`define STAP_ST_PAU_DR     4'h6
`define STAP_ST_EX2_DR     4'h7
`define STAP_ST_UPD_DR     4'h8
`define STAP_ST_SEL_IR     4'h9
`define STAP_ST_CAP_IR     4'ha
`define STAP_ST_SH_IR      4'hb
`define STAP_ST_EX1_IR     4'hc
`define STAP_ST_PAU_IR     4'hd
`define STAP_ST_EX2_IR     4'he
`define STAP_ST_UPD_IR     4'hf
// ----------------------------------------
// Data registers
// ----------------------------------------
`define STAP_ID_LEN        32
`define STAP_ID_VALUE      32'h0000_0001
`define STAP_BSR_LEN       69
`endif

// *** logic/stap_sync.v ***
`timescale 1ns/10ps
module stap_sync #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         clk,
	input  wire         nrst,
	// Data
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
		end
	end
	assign dout = s2_q;
endmodule // stap_sync

// *** logic/stap_fsm.v ***
`timescale 1ns/10ps
`include "stap_map.vh"
module stap_fsm (
	// Clock and reset
	input  wire       clk,
	input  wire       nrst,
	// Controls
	input  wire       trst_n,
	input  wire       tck_rise,
	input  wire       tms,
	// State
	output reg  [3:0] state_q
);
	reg [3:0] state_d;
	// ----------------------------------------
	// Sixteen-state controller
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
			`STAP_ST_RESET:  state_d = tms ? `STAP_ST_RESET  : `STAP_ST_IDLE;
			`STAP_ST_IDLE:   state_d = tms ? `STAP_ST_SEL_DR : `STAP_ST_IDLE;
			`STAP_ST_SEL_DR: state_d = tms ? `STAP_ST_SEL_IR : `STAP_ST_CAP_DR;
			`STAP_ST_CAP_DR: state_d = tms ? `STAP_ST_EX1_DR : `STAP_ST_SH_DR;
			`STAP_ST_SH_DR:  state_d = tms ? `STAP_ST_EX1_DR : `STAP_ST_SH_DR;
			`STAP_ST_EX1_DR: state_d = tms ? `STAP_ST_UPD_DR : `STAP_ST_PAU_DR;
			`STAP_ST_PAU_DR: state_d = tms ? `STAP_ST_EX2_DR : `STAP_ST_PAU_DR;
			`STAP_ST_EX2_DR: state_d = tms ? `STAP_ST_UPD_DR : `STAP_ST_SH_DR;
			`STAP_ST_UPD_DR: state_d = tms ? `STAP_ST_SEL_DR : `STAP_ST_IDLE;
			`STAP_ST_SEL_IR: state_d = tms ? `STAP_ST_RESET  : `STAP_ST_CAP_IR;
			`STAP_ST_CAP_IR: state_d = tms ? `STAP_ST_EX1_IR : `STAP_ST_SH_IR;
			`STAP_ST_SH_IR:  state_d = tms ? `STAP_ST_EX1_IR : `STAP_ST_SH_IR;
			`STAP_ST_EX1_IR: state_d = tms ? `STAP_ST_UPD_IR : `STAP_ST_PAU_IR;
			`STAP_ST_PAU_IR: state_d = tms ? `STAP_ST_EX2_IR : `STAP_ST_PAU_IR;
			`STAP_ST_EX2_IR: state_d = tms ? `STAP_ST_UPD_IR : `STAP_ST_SH_IR;
			`STAP_ST_UPD_IR: state_d = tms ? `STAP_ST_SEL_DR : `STAP_ST_IDLE;
			default:         state_d = `STAP_ST_RESET;
		endcase
	end
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= `STAP_ST_RESET;
		end else if (!trst_n) begin
			state_q <= `STAP_ST_RESET;
		end else if (tck_rise) begin
			state_q <= state_d;
		end
	end
endmodule // stap_fsm

// *** dv/stap_top_sva.sv ***
`timescale 1ns/10ps
module stap_top_sva #(
	parameter BSR_LEN = 69
) (
	// Clock and test port
	input wire               REF_CLK,
	input wire               NRST,
	input wire               TCK,
	input wire               TMS,
	input wire               TDI,
	input wire               TRST_N,
	// Outputs and ring
	input wire               TDO,
	input wire               TDO_OE,
	input wire [BSR_LEN-1:0] RING_IN,
	input wire               DQ_FLOAT
);
	reg       tck_q;
	reg [2:0] ones_q;
	// Counts consecutive TCK rises with TMS high, cleared by a rise with TMS low, saturating at five
	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			tck_q  <= 1'b0;
			ones_q <= 3'h0;
		end else begin
			tck_q <= TCK;
			if (TCK && !tck_q)
				ones_q <= !TMS ? 3'h0 : (ones_q == 3'h5 ? 3'h5 : ones_q + 3'h1);
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	a_tdo_idle: assert property (!TDO_OE |-> !TDO) else $error("tdo active out of shift");
	a_tdo_fall: assert property ($changed(TDO) |-> !$past(TCK)) else $error("tdo moved, tck high");
	a_oe_fall: assert property ($changed(TDO_OE) |-> !$past(TCK)) else $error("oe moved, tck high");
	a_tdo_hold: assert property (TCK && $past(TCK) |-> $stable(TDO)) else $error("tdo moved in high");
	a_float_trst: assert property (!TRST_N [*8] |-> !DQ_FLOAT) else $error("float kept in trst");
	a_five_ones: assert property (ones_q == 3'h5 |-> ##[1:12] !DQ_FLOAT) else $error("float kept");
	a_ones_oe: assert property (ones_q == 3'h5 |-> ##[1:12] !TDO_OE) else $error("oe kept");
	a_reset_vals: assert property ($rose(NRST) |-> !TDO && !TDO_OE && !DQ_FLOAT) else $error("bad reset");
endmodule // stap_top_sva

bind stap_top stap_top_sva #(.BSR_LEN(BSR_LEN)) u_sva (.REF_CLK(REF_CLK), .NRST(NRST), .TCK(TCK),
	.TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .RING_IN(RING_IN),
	.DQ_FLOAT(DQ_FLOAT));

// *** dv/stap_ctl_model.sv ***
`timescale 1ns/10ps
module stap_ctl_model (
	// Clock and return data
	input wire clk,
	input wire tdo,
	// Test port drive
	output reg tck,
	output reg tms,
	output reg tdi
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// TCK high spans four system clocks and TCK low at least five, so the synchroniser keeps up
	task step(input reg m, input reg d, output reg o);
		begin
			@(negedge clk);
			tms = m;
			tdi = d;
			repeat (4) @(negedge clk);
			tck = 1'b1;
			o = tdo;
			repeat (4) @(negedge clk);
			tck = 1'b0;
		end
	endtask
endmodule // stap_ctl_model

// *** dv/test_sram_tap_instruction_decode.sv ***
`timescale 1ns/10ps
`include "stap_map.vh"
module test_sram_tap_instruction_decode;
	reg         ref_clk  = 1'b0;
	reg         nrst     = 1'b0;
	reg         trst_n   = 1'b1;
	reg  [68:0] ring     = 69'h0;
	reg  [68:0] got;
	reg  [14:0] codes    = {3'h7, 3'h6, 3'h5, 3'h0, 3'h3};
	wire        tck, tms, tdi, tdo, tdo_oe, dq_float;
	integer     errors   = 0;
	integer     n_checks = 0;
	integer     k;
	always #50 ref_clk = ~ref_clk;
	stap_top u_dut (.REF_CLK(ref_clk), .NRST(nrst), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
		.TDO(tdo), .TDO_OE(tdo_oe), .RING_IN(ring), .DQ_FLOAT(dq_float));
	stap_ctl_model u_ctl (.clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
	task check(input [68:0] act, input [68:0] exp);
		begin
			n_checks = n_checks + 1;
			if (act !== exp) begin
				errors = errors + 1;
				$display("[FAIL] %0t got %h exp %h", $time, act, exp);
			end
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	task walk(input [7:0] pat, input integer n);
		integer i;
		reg     o;
		begin
			for (i = 0; i < n; i = i + 1)
				u_ctl.step(pat[i], i[0], o);
		end
	endtask
	task shift_ir(input [2:0] code);
		integer i;
		reg [2:0] cap;
		reg       f;
		begin
			f = dq_float;
			walk(8'h03, 4);
			for (i = 0; i < 3; i = i + 1)
				u_ctl.step(i == 2, code[i], cap[i]);
			check(dq_float, f);
			check(cap[1:0], 2'h1);
			walk(8'h01, 2);
		end
	endtask
	task shift_dr(input integer n, input [68:0] din);
		integer i;
		begin
			got = 69'h0;
			walk(8'h01, 3);
			for (i = 0; i < n; i = i + 1)
				u_ctl.step(i == n - 1, din[i], got[i]);
			check(tdo_oe, 1'b1);
			walk(8'h01, 2);
			check(tdo_oe, 1'b0);
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (5) @(negedge ref_clk);
		walk(8'h00, 1);
		shift_dr(32, 69'h0);
		check(got[31:0], `STAP_ID_VALUE);
		// Reserved codes are loaded on purpose: they must fall back to bypass
		for (k = 0; k < 5; k = k + 1) begin
			shift_ir(codes[3*k +: 3]);
			shift_dr(8, 69'ha5);
			check(got[7:1], 7'h25);
			check(dq_float, 1'b0);
		end
		ring = {5'h15, 64'h0123_4567_89ab_cdef};
		shift_ir(`STAP_OP_SAMPLE);
		shift_dr(69, ~ring);
		check(got, ring);
		check(dq_float, 1'b0);
		shift_ir(`STAP_OP_HIGHZ);
		check(dq_float, 1'b1);
		shift_dr(8, 69'ha5);
		check(got[7:1], 7'h25);
		walk(8'h3f, 6);
		check(dq_float, 1'b0);
		walk(8'h00, 1);
		shift_ir(`STAP_OP_HIGHZ);
		trst_n = 1'b0;
		repeat (10) @(negedge ref_clk);
		check(dq_float, 1'b0);
		trst_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		results;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		errors = errors + 1;
		results;
	end
endmodule // test_sram_tap_instruction_decode
